// file: logic/rpc_ctrl.sv
// Reset and power-on controller top: merges reset causes, runs the
// power-on sequence and hosts the watchdog and soft-reset registers.
// Assumes synchronous inputs on mclk_in and a one-cycle register port.
// Assumes both oscillator inputs toggle slower than half of mclk_in.
// Limitation: a cause shorter than one mclk_in cycle can be missed.
`timescale 1ns/1ps
`include "rpc_defs.svh"
module rpc_ctrl
  import rpc_pkg::*;
#(
  parameter rpc_wd_mode_t WD_MODE = RPC_WD_ENABLE,
  parameter logic [1:0] WD_DIV_SEL = 2'h0,
  parameter rpc_pin_mode_t PIN_MODE = RPC_PIN_RST_DEB,
  parameter logic [1:0] CLK_SRC_OPT = 2'h0,
  parameter int PWR_STAB_CYC = `RPC_PWR_STAB_CYC,
  parameter int DEBOUNCE_CYC = `RPC_DEBOUNCE_CYC
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Supply and oscillators
  input wire logic low_voltage_detector_in,
  input wire logic low_speed_oscillator_in,
  input wire logic sel_clk_in,
  // Shared reset pin
  input wire logic shared_reset_gpio_pin_in,
  output logic gpio_in_out,
  // CPU mode
  input wire rpc_op_mode_t op_mode_in,
  // Core control
  output logic core_rst_out,
  output logic sys_rst_out,
  output logic [1:0] clk_src_sel_out,
  output logic clk_src_en_out,
  output logic [15:0] reset_vector_out
);
  rpc_wd_if wd_link ();

  // ----------------------------------------------------------------
  // Edge detection of oscillators (inputs synchronous to mclk_in)
  // ----------------------------------------------------------------
  logic lso_q;
  logic sel_q;
  logic lso_rise;
  logic sel_rise;

  // Previous oscillator levels
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      lso_q <= 1'b0;
      sel_q <= 1'b0;
    end else begin
      lso_q <= low_speed_oscillator_in;
      sel_q <= sel_clk_in;
    end
  end

  assign lso_rise = low_speed_oscillator_in && !lso_q;
  assign sel_rise = sel_clk_in && !sel_q;

  // ----------------------------------------------------------------
  // Watchdog prescaler
  // ----------------------------------------------------------------
  logic [4:0] pre_cnt;
  logic wd_tick;

  // Division ratio from the period option
  function automatic logic [4:0] div_top(input logic [1:0] sel);
    case (sel)
      2'h0: div_top = 5'h03;
      2'h1: div_top = 5'h07;
      2'h2: div_top = 5'h0F;
      default: div_top = 5'h1F;
    endcase
  endfunction

  // Watchdog run enable and key-write clear
  logic wd_run;
  logic wd_clr_wr;

  // counting depends on option and CPU mode
  always_comb begin
    case (WD_MODE)
      RPC_WD_ALWAYS: wd_run = 1'b1;
      RPC_WD_ENABLE: wd_run = (op_mode_in == RPC_OP_NORMAL);
      default: wd_run = 1'b0;
    endcase
  end

  // Low-speed clock divided by 4, 8, 16 or 32
  always_ff @(posedge mclk_in) begin
    if (rst_in || wd_clr_wr) begin
      pre_cnt <= 5'h00;
    end else if (wd_run && lso_rise) begin
      pre_cnt <= (pre_cnt == div_top(WD_DIV_SEL)) ? 5'h00 : pre_cnt + 5'h01;
    end
  end

  // One tick per full turn of the prescaler
  assign wd_tick = wd_run && lso_rise && (pre_cnt == div_top(WD_DIV_SEL));

  // Key write restarts prescaler and counter; core reset holds only the counter clear
  assign wd_clr_wr = reg_wr_in && (reg_addr_in == `RPC_OFS_WDCLR)
                     && (reg_wdata_in == `RPC_WD_KEY);
  assign wd_link.tick = wd_tick;
  assign wd_link.clear = wd_clr_wr || core_rst_out;
  assign wd_link.run = wd_run;

  // Watchdog counter
  rpc_watchdog rpc_watchdog_inst (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .wd(wd_link.wd)
  );

  // ----------------------------------------------------------------
  // Reset pin
  // ----------------------------------------------------------------
  logic pin_en;
  logic [`RPC_CNT_W-1:0] deb_cnt;
  logic pin_rst;

  // Pin acts as a reset source unless the GPIO option is chosen
  assign pin_en = (PIN_MODE != RPC_PIN_GPIO);

  // Count continuous low time for the debounced option
  always_ff @(posedge mclk_in) begin
    if (rst_in || shared_reset_gpio_pin_in) begin
      deb_cnt <= `RPC_CNT_ZERO;
    end else if (deb_cnt != DEBOUNCE_CYC[`RPC_CNT_W-1:0]) begin
      deb_cnt <= deb_cnt + `RPC_CNT_ONE;
    end
  end

  // Pin reset request, held while low
  always_comb begin
    case (PIN_MODE)
      RPC_PIN_RST_NODEB: pin_rst = !shared_reset_gpio_pin_in;
      RPC_PIN_RST_DEB: pin_rst = !shared_reset_gpio_pin_in
                                 && (deb_cnt == DEBOUNCE_CYC[`RPC_CNT_W-1:0]);
      default: pin_rst = 1'b0;
    endcase
  end

  // Pin level reaches the port logic only in GPIO option
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      gpio_in_out <= 1'b1;
    end else begin
      gpio_in_out <= pin_en ? 1'b1 : shared_reset_gpio_pin_in;
    end
  end

  // ----------------------------------------------------------------
  // Software reset request
  // ----------------------------------------------------------------
  logic soft_reset_request;
  logic soft_wr;
  logic soft_rst;

  assign soft_wr = reg_wr_in && (reg_addr_in == `RPC_OFS_SOFT);
  assign soft_rst = soft_wr && reg_wdata_in[`RPC_BIT_SOFTREQ]
                    && soft_reset_request;

  // Request bit remembers a first set; any other write breaks the pair
  always_ff @(posedge mclk_in) begin
    if (rst_in || core_rst_out) begin
      soft_reset_request <= 1'b0;
    end else if (soft_rst) begin
      soft_reset_request <= 1'b0;
    end else if (soft_wr) begin
      soft_reset_request <= reg_wdata_in[`RPC_BIT_SOFTREQ];
    end else if (reg_wr_in) begin
      soft_reset_request <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Cause merge
  // ----------------------------------------------------------------
  logic hw_cause;
  logic any_cause;

  // Hardware causes restart the sequence; software only pulses reset
  assign hw_cause = low_voltage_detector_in || wd_link.expire || pin_rst;
  assign any_cause = hw_cause || soft_rst;

  // ----------------------------------------------------------------
  // Power-on sequence
  // ----------------------------------------------------------------
  rpc_seq_t seq;
  logic [`RPC_CNT_W-1:0] seq_cnt;
  logic [1:0] clk_src_sel;

  // stages in order, any hardware cause restarts
  always_ff @(posedge mclk_in) begin
    if (rst_in || hw_cause) begin
      seq <= RPC_SEQ_PWR;
      seq_cnt <= `RPC_CNT_ZERO;
    end else begin
      case (seq)
        RPC_SEQ_PWR: begin
          if (seq_cnt == PWR_STAB_CYC[`RPC_CNT_W-1:0]) begin
            seq <= RPC_SEQ_CLK;
            seq_cnt <= `RPC_CNT_ZERO;
          end else begin
            seq_cnt <= seq_cnt + `RPC_CNT_ONE;
          end
        end
        RPC_SEQ_CLK: begin
          if (sel_rise) begin
            if (seq_cnt == (`RPC_CLK_STAB_CNT - 1)) begin
              seq <= RPC_SEQ_LSO;
              seq_cnt <= `RPC_CNT_ZERO;
            end else begin
              seq_cnt <= seq_cnt + `RPC_CNT_ONE;
            end
          end
        end
        RPC_SEQ_LSO: begin
          if (lso_rise) begin
            if (seq_cnt == (`RPC_LSO_STAB_CNT - 1)) begin
              seq <= RPC_SEQ_RUN;
              seq_cnt <= `RPC_CNT_ZERO;
            end else begin
              seq_cnt <= seq_cnt + `RPC_CNT_ONE;
            end
          end
        end
        RPC_SEQ_RUN: begin
          // Stay here until a new hardware cause
          seq <= RPC_SEQ_RUN;
        end
        default: begin
          seq <= RPC_SEQ_PWR;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Clock source option
  // ----------------------------------------------------------------
  // Clock source option loaded at the end of power stabilization
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      clk_src_sel <= 2'h0;
    end else if (seq == RPC_SEQ_PWR && seq_cnt == PWR_STAB_CYC[`RPC_CNT_W-1:0]) begin
      clk_src_sel <= CLK_SRC_OPT;
    end
  end

  // ----------------------------------------------------------------
  // Software reset pulse
  // ----------------------------------------------------------------
  logic soft_hold;

  // Software reset: two-cycle core and system reset, no sequence
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      soft_hold <= 1'b0;
    end else begin
      soft_hold <= soft_rst;
    end
  end

  // ----------------------------------------------------------------
  // Core and system reset outputs
  // ----------------------------------------------------------------
  // Core outputs from flip-flops
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      core_rst_out <= 1'b1;
      sys_rst_out <= 1'b1;
      clk_src_en_out <= 1'b0;
    end else begin
      core_rst_out <= any_cause || (seq != RPC_SEQ_RUN) || soft_hold;
      sys_rst_out <= any_cause || (seq == RPC_SEQ_PWR) || soft_hold;
      clk_src_en_out <= (seq != RPC_SEQ_PWR) && !hw_cause;
    end
  end

  assign clk_src_sel_out = clk_src_sel;
  assign reset_vector_out = 16'h0000;

  // ----------------------------------------------------------------
  // Cause flags and read port
  // ----------------------------------------------------------------
  logic [7:0] cause;

  // Latest reset cause; register values otherwise survive nothing
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cause <= `RPC_ZERO8;
    end else if (any_cause) begin
      cause <= `RPC_ZERO8;
      cause[`RPC_BIT_LVD] <= low_voltage_detector_in;
      cause[`RPC_BIT_WDT] <= wd_link.expire;
      cause[`RPC_BIT_PIN] <= pin_rst;
      cause[`RPC_BIT_SOFT] <= soft_rst;
    end
  end

  // Read data in the cycle after the strobe
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      reg_rdata_out <= `RPC_ZERO8;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `RPC_OFS_CAUSE: reg_rdata_out <= cause;
        `RPC_OFS_SOFT: reg_rdata_out <= {7'h00, soft_reset_request};
        `RPC_OFS_STAT: reg_rdata_out <= wd_link.count;
        default: reg_rdata_out <= `RPC_ZERO8;
      endcase
    end else begin
      reg_rdata_out <= `RPC_ZERO8;
    end
  end
endmodule // rpc_ctrl

// file: pkg/rpc_defs.svh
// Constants of the reset and power-on controller: register offsets,
// field positions, reset values and timing figures.
// Assumes inclusion by bare name from package and logic files.
`ifndef RPC_DEFS_SVH
`define RPC_DEFS_SVH

// ----------------------------------------------------------------
// Register map (byte offsets on the plain register port)
// ----------------------------------------------------------------
`define RPC_ADDR_W 8
`define RPC_OFS_CAUSE 8'h00
`define RPC_OFS_SOFT 8'h01
`define RPC_OFS_WDCLR 8'h02
`define RPC_OFS_STAT 8'h03
`define RPC_WD_KEY 8'h5A
`define RPC_BIT_SOFTREQ 0
`define RPC_BIT_LVD 7
`define RPC_BIT_WDT 6
`define RPC_BIT_PIN 5
`define RPC_BIT_SOFT 4
`define RPC_ZERO8 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RPC_CLK_HZ 20000000
`define RPC_PWR_STAB_US 4600
`define RPC_PWR_STAB_CYC ((`RPC_PWR_STAB_US * (`RPC_CLK_HZ / 1000000)) - 1)
`define RPC_DEBOUNCE_US 8000
`define RPC_DEBOUNCE_CYC ((`RPC_DEBOUNCE_US * (`RPC_CLK_HZ / 1000000)) - 1)
`define RPC_CLK_STAB_CNT 2048
`define RPC_LSO_STAB_CNT 5
`define RPC_WD_TOP 8'hFF
`define RPC_CNT_W 20
`define RPC_CNT_ONE 20'h00001
`define RPC_CNT_ZERO 20'h00000

`endif

// file: pkg/rpc_pkg.sv
// Types of the reset and power-on controller.
// Assumes rpc_defs.svh is reachable on the include path.
package rpc_pkg;
  `include "rpc_defs.svh"

  // Watchdog code option
  typedef enum logic [1:0] {
    RPC_WD_DISABLE,
    RPC_WD_ENABLE,
    RPC_WD_ALWAYS
  } rpc_wd_mode_t;

  // Reset pin code option
  typedef enum logic [1:0] {
    RPC_PIN_RST_DEB,
    RPC_PIN_RST_NODEB,
    RPC_PIN_GPIO
  } rpc_pin_mode_t;

  // CPU operating mode
  typedef enum logic [1:0] {
    RPC_OP_NORMAL,
    RPC_OP_IDLE,
    RPC_OP_STOP
  } rpc_op_mode_t;

  // Power-on sequence states
  typedef enum logic [1:0] {
    RPC_SEQ_PWR,
    RPC_SEQ_CLK,
    RPC_SEQ_LSO,
    RPC_SEQ_RUN
  } rpc_seq_t;
endpackage

// file: pkg/rpc_wd_if.sv
// Link between the controller top and its watchdog counter.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface rpc_wd_if;
  logic tick;
  logic clear;
  logic run;
  logic expire;
  logic [7:0] count;

  modport ctrl (
    output tick,
    output clear,
    output run,
    input expire,
    input count
  );
  modport wd (
    input tick,
    input clear,
    input run,
    output expire,
    output count
  );
endinterface

// file: logic/rpc_watchdog.sv
// Watchdog timer: 8-bit counter stepped by prescaled ticks.
// Assumes ticks, clear and run come from the controller top.
`timescale 1ns/1ps
`include "rpc_defs.svh"
module rpc_watchdog
  import rpc_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Controller link
  rpc_wd_if.wd wd
);
  logic [7:0] count;

  // Count ticks while running; overflow pulses expire
  always_ff @(posedge mclk_in) begin
    if (rst_in || wd.clear) begin
      count <= `RPC_ZERO8;
    end else if (wd.run && wd.tick) begin
      count <= count + 8'h01;
    end
  end

  assign wd.expire = wd.run && wd.tick && (count == `RPC_WD_TOP) && !wd.clear;
  assign wd.count = count;
endmodule // rpc_watchdog

// file: verification/rpc_pin_partner.sv
// Model of the party that drives the shared reset pin.
// Assumes commands from the bench on the rising clock edge.
`timescale 1ns/1ps
module rpc_pin_partner (
  // Clock and command
  input wire logic mclk_in,
  input wire logic go_in,
  input wire logic [7:0] len_in,
  // Reset pin level
  output logic pin_out
);
  logic [7:0] left = 8'h00;
  logic level = 1'b1;
  // Pin held low for len_in sampled cycles, high when idle
  always @(posedge mclk_in) begin
    if (go_in)
      left <= len_in;
    else if (left != 8'h00)
      left <= left - 8'h01;
    level <= !(go_in || left > 8'h01);
  end
  assign pin_out = level;
endmodule // rpc_pin_partner

// file: verification/rpc_ctrl_properties.sv
// Port checker of the reset and power-on controller.
// Assumes it is bound to rpc_ctrl and sees only its ports.
`timescale 1ns/1ps
module rpc_ctrl_properties
  import rpc_pkg::*;
#(
  parameter rpc_pin_mode_t PIN_MODE = RPC_PIN_RST_DEB,
  parameter logic [1:0] CLK_SRC_OPT = 2'h0,
  parameter int DEBOUNCE_CYC = 10
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Inputs watched
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic low_voltage_detector_in,
  input wire logic sel_clk_in,
  input wire logic shared_reset_gpio_pin_in,
  input wire logic reg_rd_in,
  // Outputs watched
  input wire logic [7:0] reg_rdata_out,
  input wire logic gpio_in_out,
  input wire logic core_rst_out,
  input wire logic sys_rst_out,
  input wire logic [1:0] clk_src_sel_out,
  input wire logic clk_src_en_out,
  input wire logic [15:0] reset_vector_out
);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  logic sel_d;
  logic [11:0] edge_cnt;
  logic [7:0] low_cnt;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // Selected clock rises seen while the core is held
  always_ff @(posedge mclk_in) begin
    sel_d <= sel_clk_in;
    if (rst_in || !clk_src_en_out || !core_rst_out)
      edge_cnt <= 12'h000;
    else if (sel_clk_in && !sel_d && edge_cnt != 12'hFFF)
      edge_cnt <= edge_cnt + 12'h001;
  end
  // Length of the present low level on the reset pin
  always_ff @(posedge mclk_in) begin
    if (rst_in || shared_reset_gpio_pin_in)
      low_cnt <= 8'h00;
    else if (low_cnt != 8'hFF)
      low_cnt <= low_cnt + 8'h01;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_soft_set;
    reg_wr_in && reg_addr_in == 8'h01 && reg_wdata_in == 8'h01;
  endsequence
  sequence s_soft_pair;
    s_soft_set ##1 !reg_wr_in [*2] ##1 s_soft_set;
  endsequence
  a_vector_zero: assert property (reset_vector_out == 16'h0000)
    else $error("reset vector is not zero");
  a_lvd_resets: assert property (low_voltage_detector_in |-> ##[1:2] (sys_rst_out && core_rst_out))
    else $error("low supply did not reset");
  a_sys_holds_core: assert property (sys_rst_out |-> core_rst_out)
    else $error("core free during system reset");
  a_soft_pulse: assert property (s_soft_pair ##0 !core_rst_out |-> ##1 (core_rst_out && sys_rst_out) [*2] ##1 !core_rst_out)
    else $error("soft reset pulse wrong");
  a_wd_clear: assert property ((reg_wr_in && reg_addr_in == 8'h02 && reg_wdata_in == 8'h5A) ##1 (reg_rd_in && reg_addr_in == 8'h03) |=> reg_rdata_out == 8'h00)
    else $error("watchdog count not cleared");
  a_clk_loaded: assert property ($rose(clk_src_en_out) |-> core_rst_out && clk_src_sel_out == CLK_SRC_OPT)
    else $error("clock option not loaded");
  a_stab_count: assert property ($fell(core_rst_out) && $past(core_rst_out, 3) |-> edge_cnt >= 12'h800)
    else $error("core released before clock count");
  a_pin_long: assert property (PIN_MODE != RPC_PIN_GPIO && low_cnt == (PIN_MODE == RPC_PIN_RST_DEB ? DEBOUNCE_CYC + 1 : 1) |-> ##[0:2] core_rst_out)
    else $error("low pin did not reset");
  a_pin_short: assert property (PIN_MODE == RPC_PIN_RST_DEB && !shared_reset_gpio_pin_in && low_cnt < DEBOUNCE_CYC && !core_rst_out |=> !core_rst_out)
    else $error("short pin pulse reset");
  a_gpio_idle: assert property (PIN_MODE != RPC_PIN_GPIO |-> gpio_in_out)
    else $error("gpio level in reset mode");
endmodule // rpc_ctrl_properties

bind rpc_ctrl rpc_ctrl_properties #(.PIN_MODE(PIN_MODE), .CLK_SRC_OPT(CLK_SRC_OPT),
  .DEBOUNCE_CYC(DEBOUNCE_CYC)) rpc_ctrl_properties_inst (.mclk_in(mclk_in), .rst_in(rst_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .low_voltage_detector_in(low_voltage_detector_in), .sel_clk_in(sel_clk_in),
  .shared_reset_gpio_pin_in(shared_reset_gpio_pin_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .gpio_in_out(gpio_in_out), .core_rst_out(core_rst_out),
  .sys_rst_out(sys_rst_out), .clk_src_sel_out(clk_src_sel_out),
  .clk_src_en_out(clk_src_en_out), .reset_vector_out(reset_vector_out));

// file: verification/tb_rpc_ctrl.sv
// Self-checking bench of the reset and power-on controller.
// Assumes short power and debounce counts set by parameter.
`timescale 1ns/1ps
module tb_rpc_ctrl
  import rpc_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus and design
  // ----------------------------------------------------------------
  localparam int PWR = 20;
  localparam int DEB = 10;
  localparam logic [1:0] CSO = 2'h2;
  // Rows: write address, write data, read address, read data
  localparam logic [31:0] ROWS [7] = '{32'h04FF0400, 32'h025A0300, 32'h01010101,
    32'h01000100, 32'h01010101, 32'h8000FF00, 32'h0101FF00};
  localparam rpc_op_mode_t MODES [3] = '{RPC_OP_IDLE, RPC_OP_STOP, RPC_OP_NORMAL};
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic low_voltage_detector = 1'b0;
  logic lso = 1'b0;
  logic sclk = 1'b0;
  logic go = 1'b0;
  logic [7:0] len = 8'h00;
  logic [1:0] k = 2'h0;
  rpc_op_mode_t op = RPC_OP_NORMAL;
  logic pin2 = 1'b1;
  logic pin, core, sys, clk_en, gpio, core2, gpio2;
  logic [7:0] rdata, d, rdata2, d2;
  logic [1:0] csel;
  logic [15:0] vec;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_cyc;
  // Main clock, selected clock and slow oscillator
  always #25 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    sclk <= ~sclk;
    k <= k + 2'h1;
    lso <= lso ^ (k == 2'h3);
  end
  rpc_ctrl #(.WD_MODE(RPC_WD_ENABLE), .WD_DIV_SEL(2'h0), .PIN_MODE(RPC_PIN_RST_DEB),
    .CLK_SRC_OPT(CSO), .PWR_STAB_CYC(PWR), .DEBOUNCE_CYC(DEB)) rpc_ctrl_inst (
    .mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .low_voltage_detector_in(low_voltage_detector),
    .low_speed_oscillator_in(lso), .sel_clk_in(sclk), .shared_reset_gpio_pin_in(pin),
    .gpio_in_out(gpio), .op_mode_in(op), .core_rst_out(core), .sys_rst_out(sys),
    .clk_src_sel_out(csel), .clk_src_en_out(clk_en), .reset_vector_out(vec));
  rpc_pin_partner rpc_pin_partner_inst (.mclk_in(mclk_in), .go_in(go), .len_in(len),
    .pin_out(pin));
  // Second controller: always-on watchdog, slower period, undebounced pin
  if (1) begin : g_alt
    rpc_ctrl #(.WD_MODE(RPC_WD_ALWAYS), .WD_DIV_SEL(2'h1), .PIN_MODE(RPC_PIN_RST_NODEB),
      .CLK_SRC_OPT(CSO), .PWR_STAB_CYC(PWR), .DEBOUNCE_CYC(DEB)) rpc_ctrl_inst (
      .mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata2), .low_voltage_detector_in(low_voltage_detector),
      .low_speed_oscillator_in(lso), .sel_clk_in(sclk), .shared_reset_gpio_pin_in(pin2),
      .gpio_in_out(gpio2), .op_mode_in(op), .core_rst_out(core2), .sys_rst_out(),
      .clk_src_sel_out(), .clk_src_en_out(), .reset_vector_out());
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task wrt(input logic [7:0] a, input logic [7:0] v);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask
  task rdr(input logic [7:0] a, output logic [7:0] v);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1 v = rdata;
    d2 = rdata2;
    @(posedge mclk_in);
  endtask
  // Bounded wait for the core reset of either controller to reach a level
  task wt(input logic v, input int lim, input bit alt = 1'b0);
    n_cyc = 0;
    while (((alt ? core2 : core) !== v) && n_cyc < lim) begin
      @(posedge mclk_in);
      #1 n_cyc++;
    end
    if ((alt ? core2 : core) !== v) begin
      n_mismatch++;
      results();
    end
  endtask
  task results();
    if (n_mismatch == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(20);
    rst_in <= 1'b0;
    #1 chk("core", core, 16'h1);
    chk("sys", sys, 16'h1);
    chk("clk_en", clk_en, 16'h0);
    chk("rdata", rdata, 16'h0);
    wt(1'b0, 6000);
    chk("run_len", n_cyc >= PWR + 4096, 16'h1);
    chk("clk_sel", csel, CSO);
    chk("vector", vec, 16'h0000);
    chk("gpio", gpio, 16'h1);
    foreach (ROWS[i]) begin
      wrt(ROWS[i][31:24], ROWS[i][23:16]);
      rdr(ROWS[i][15:8], d);
      chk("row_rdata", d, ROWS[i][7:0]);
      chk("row_core", core, 16'h0);
    end
    wrt(8'h01, 8'h01);
    cyc(1);
    #1 chk("soft_core", core, 16'h1);
    cyc(3);
    #1 chk("soft_end", core, 16'h0);
    rdr(8'h00, d);
    chk("soft_cause", d, 8'h10);
    rdr(8'h01, d);
    chk("soft_clear", d, 8'h00);
    go <= 1'b1;
    len <= 8'(DEB);
    @(posedge mclk_in);
    go <= 1'b0;
    cyc(15);
    #1 chk("pin_short", core, 16'h0);
    go <= 1'b1;
    len <= 8'h14;
    @(posedge mclk_in);
    go <= 1'b0;
    cyc(14);
    #1 chk("pin_long", core, 16'h1);
    wt(1'b0, 6000);
    rdr(8'h00, d);
    chk("pin_cause", d, 8'h20);
    low_voltage_detector <= 1'b1;
    cyc(2);
    low_voltage_detector <= 1'b0;
    cyc(200);
    #1 chk("lvd_hold", core, 16'h1);
    low_voltage_detector <= 1'b1;
    cyc(2);
    low_voltage_detector <= 1'b0;
    wt(1'b0, 6000);
    chk("lvd_restart", n_cyc >= PWR + 4096, 16'h1);
    rdr(8'h00, d);
    chk("lvd_cause", d, 8'h80);
    foreach (MODES[i]) begin
      wrt(8'h02, 8'h5A);
      op <= MODES[i];
      cyc(i < 2 ? 9000 : 4000);
      #1 chk("wd_core", core, 16'h0);
      rdr(8'h03, d);
      if (i < 2)
        chk("wd_count", d, 8'h00);
    end
    wrt(8'h02, 8'h5A);
    wt(1'b1, 10000);
    chk("wd_period", n_cyc > 8100 && n_cyc < 8230, 16'h1);
    wt(1'b0, 6000);
    rdr(8'h00, d);
    chk("wd_cause", d, 8'h40);
    wrt(8'h02, 8'h5A);
    op <= RPC_OP_IDLE;
    wt(1'b1, 17000, 1'b1);
    chk("alt_wd_idle", n_cyc > 16300 && n_cyc < 16420, 16'h1);
    chk("idle_main", core, 16'h0);
    wt(1'b0, 6000, 1'b1);
    rdr(8'h00, d);
    chk("alt_wd_cause", d2, 8'h40);
    pin2 <= 1'b0;
    cyc(2);
    #1 chk("alt_pin_now", core2, 16'h1);
    cyc(20);
    #1 chk("alt_pin_hold", core2, 16'h1);
    chk("alt_gpio", gpio2, 16'h1);
    pin2 <= 1'b1;
    wt(1'b0, 6000, 1'b1);
    chk("alt_pin_seq", n_cyc >= PWR + 4096, 16'h1);
    rdr(8'h00, d);
    chk("alt_pin_cause", d2, 8'h20);
    chk("alt_main_free", core, 16'h0);
    results();
  end
endmodule // tb_rpc_ctrl
